// file: verification/rxctl_engine_tb_top.sv
// self-checking bench for the receive-engine control block
`timescale 1ns/1ps
module rxctl_engine_tb_top;
  import rxctl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fa = 1'b0, done = 1'b1, dd = 1'b0, eol = 1'b0, sus = 1'b0, hdr = 1'b0;
  logic fl = 1'b0, req = 1'b0, stall = 1'b0, mv = 1'b0;
  logic cv, clr, sv, sr, dis, hlt, receiver_not_ready_event, fev, upd;
  logic [15:0] link = 16'h0000, lf = 16'hac78, nxt, drops_o, hds_o, sw;
  rxctl_cmd_type rc = '0, ci;
  rxctl_setup_type so;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  int bad_count = 0, total_checks = 0, st = 0, drops = 0, pend = 0, rp = 0, line = 0;
  int n_ev = 0, n_rnr = 0, n_hlt = 0, n_upd = 0, n_clr = 0, v0;

  always #25 clk_i = ~clk_i;

  rxctl_engine dut (.clk_i(clk_i), .rst_i(rst_i), .frame_active_i(fa), .data_moved_i(mv),
    .cmd_valid_i(cv), .cmd_engine_done_i(done), .cmd_i(ci), .cmd_clear_o(clr),
    .desc_done_i(dd), .desc_eol_i(eol), .desc_susp_i(sus), .desc_link_i(link),
    .hdr_done_i(hdr), .flagged_cmd_done_i(fl), .setup_valid_o(sv), .setup_ready_i(sr),
    .setup_o(so), .discard_o(dis), .dma_halt_o(hlt), .rnr_event_o(receiver_not_ready_event),
    .frame_event_o(fev), .status_word_o(sw), .status_update_o(upd),
    .nores_drops_o(drops_o), .hdr_size_o(hds_o));
  rxctl_host_model host (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .req_cmd_i(rc),
    .cmd_clear_i(clr), .cmd_valid_o(cv), .cmd_o(ci), .stall_i(stall), .setup_ready_o(sr));

  // ====
  // helpers
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : rnd

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, want);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // pulse counters and set-up matching; release bit checked only where known
  // taken at the falling edge, so the tasks never race the counts at the rising edge
  always @(negedge clk_i)
  begin
    n_ev += (fev === 1'b1);
    n_rnr += (receiver_not_ready_event === 1'b1);
    n_hlt += (hlt === 1'b1);
    n_upd += (upd === 1'b1);
    n_clr += (clr === 1'b1);
    if (!rst_i && sv === 1'b1 && sr === 1'b1)
    begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 18'h3ffff;
      check(e[17] ? so : {1'b0, so.ptr}, e[17] ? e[16:0] : {1'b0, e[15:0]});
    end
  end

  // ====
  // reference model of acceptance-time actions; no begin or continue while ready
  task automatic model_cmd(input logic [2:0] code, input logic [15:0] p);
    if (code == 3'h4)
    begin
      pend = 0;
      rp = 0;
      st = 0;
    end
    else if (code == 3'h1)
    begin
      nxt = p;
      pend = line;
      if (line == 0 && mv == 1'b0)
        st = 4;
      if (line == 0 && mv == 1'b0)
        exp_q.push_back({2'b11, p});
    end
    else if (code == 3'h2 && st == 1 && line == 1)
      rp = 1;
    else if (code == 3'h2 && st == 1)
    begin
      st = 4;
      exp_q.push_back({2'b00, nxt});
    end
  endtask : model_cmd

  // one command through the command byte, acceptance held off for hold cycles
  task automatic cmd(input logic [2:0] code, input logic [15:0] p, input int hold);
    int k;
    int h0;
    int r0;
    int c0;
    int s0;
    k = 0;
    s0 = st;
    h0 = n_hlt;
    r0 = n_rnr;
    c0 = n_clr;
    req <= 1'b1;
    rc <= {code, p};
    if (hold > 0)
      done <= 1'b0;
    tick(1);
    req <= 1'b0;
    tick(hold);
    check(n_clr, c0);
    done <= 1'b1;
    while (clr !== 1'b1 && k < 40)
    begin
      tick(1);
      k++;
    end
    check(clr, 1'b1);
    model_cmd(code, p); // expectation queued before the set-up can reach the dma side
    tick(1);
    check(n_hlt - h0, code == 3'h4);
    check(n_rnr - r0, code == 3'h4 && s0 == 4);
    check(upd, 1'b1);
    check(sw, st << 2);
    check(dis, st != 4);
    if (code == 3'h5)
      check(hds_o, p);
  endtask : cmd

  // one retired descriptor with its flags and a random link
  task automatic desc(input logic e_l, input logic s_p);
    v0 = n_ev;
    link <= rnd();
    dd <= 1'b1;
    eol <= e_l;
    sus <= s_p;
    tick(1);
    dd <= 1'b0;
    if (st == 4)
    begin
      nxt = link;
      st = e_l ? 2 : s_p ? 1 : 4;
      if (st == 4)
        exp_q.push_back({2'b10, link});
    end
    tick(2);
    check(n_ev - v0, 1);
    check(sw, st << 2);
  endtask : desc

  // a frame on the line, optionally with a command in its middle
  task automatic frame(input logic [2:0] code, input logic [15:0] p);
    fa <= 1'b1;
    line = 1;
    tick(4);
    if (code != 3'h0)
      cmd(code, p, 0);
    tick(3);
    fa <= 1'b0;
    line = 0;
    if (st == 2)
      drops++;
    if (pend == 1 || (rp == 1 && st == 1))
      exp_q.push_back({pend == 1, 1'b0, nxt});
    if (pend == 1 || (rp == 1 && st == 1))
      st = 4;
    pend = 0;
    rp = 0;
    tick(5);
    check(sw, st << 2);
    check(drops_o, drops);
  endtask : frame

  // ====
  // main sequence
  initial
  begin
    tick(8);
    rst_i <= 1'b0;
    tick(2);
    check(sw, 0);
    check(dis, 1'b1);
    cmd(3'h2, rnd(), 0);
    cmd(3'h4, rnd(), 3);
    frame(3'h1, rnd());
    $display("test idle commands done");
    cmd(3'h4, 16'h0000, 0);
    cmd(3'h1, rnd(), 0);
    desc(1'b0, 1'b0);
    v0 = n_ev;
    hdr <= 1'b1;
    tick(1);
    hdr <= 1'b0;
    tick(2);
    check(n_ev - v0, 1);
    stall <= 1'b1;
    repeat (3) desc(1'b0, 1'b0);
    check(sv, 1'b1);
    stall <= 1'b0;
    tick(8);
    check(exp_q.size(), 0);
    $display("test ready and buffer done");
    desc(1'b0, 1'b1);
    frame(3'h2, 16'h0000);
    desc(1'b0, 1'b1);
    cmd(3'h2, 16'h0000, 0);
    desc(1'b1, 1'b0);
    frame(3'h0, 16'h0000);
    frame(3'h1, rnd());
    $display("test suspend and no-resources done");
    cmd(3'h4, 16'h0000, 0);
    cmd(3'h5, rnd(), 0);
    mv <= 1'b1;
    cmd(3'h1, rnd(), 0);
    mv <= 1'b0;
    v0 = n_upd;
    fl <= 1'b1;
    tick(1);
    fl <= 1'b0;
    tick(3);
    check(n_upd - v0, 1);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    st = 0;
    drops = 0;
    tick(2);
    check(sw, 0);
    check(drops_o, drops);
    check(exp_q.size(), 0);
    $display("test halt, header size and reset done");
    close_out();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    tick(5000);
    bad_count++;
    close_out();
  end
endmodule : rxctl_engine_tb_top

// file: verification/rxctl_host_model.sv
// host driver and receive dma model facing the receive-engine control block
`timescale 1ns/1ps
module rxctl_host_model
  import rxctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire rxctl_cmd_type req_cmd_i,
  input wire logic cmd_clear_i,
  output logic cmd_valid_o,
  output rxctl_cmd_type cmd_o,
  input wire logic stall_i,
  output logic setup_ready_o
);
  // ====
  // command byte: one command at a time, held until the device clears it
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
    end
    else if (cmd_valid_o && cmd_clear_i)
    begin
      cmd_valid_o <= 1'b0; // next command only after the clear
      cmd_o <= ~cmd_o; // a released byte must not look valid
    end
    else if (req_i && !cmd_valid_o)
    begin
      cmd_valid_o <= 1'b1; // receive commands only, never mixed
      cmd_o <= req_cmd_i;
    end
  end

  // dma takes set-ups at once unless the bench stalls it
  assign setup_ready_o = !stall_i;
endmodule : rxctl_host_model

// file: verilog/rxctl_engine.sv
// receive_engine control state machine with command acceptance and status word
`timescale 1ns/1ps
module rxctl_engine
  import rxctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic frame_active_i,
  input wire logic data_moved_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_engine_done_i,
  input wire rxctl_cmd_type cmd_i,
  output logic cmd_clear_o,
  input wire logic desc_done_i,
  input wire logic desc_eol_i,
  input wire logic desc_susp_i,
  input wire logic [PTR_W-1:0] desc_link_i,
  input wire logic hdr_done_i,
  input wire logic flagged_cmd_done_i,
  output logic setup_valid_o,
  input wire logic setup_ready_i,
  output rxctl_setup_type setup_o,
  output logic discard_o,
  output logic dma_halt_o,
  output logic rnr_event_o,
  output logic frame_event_o,
  output logic [STAT_W-1:0] status_word_o,
  output logic status_update_o,
  output logic [CNT_W-1:0] nores_drops_o,
  output logic [HDS_W-1:0] hdr_size_o
);

  // ==========================================================
  // state
  rxctl_state_type state_r;
  rxctl_state_type state_nxt;
  logic act_s1_r;
  logic act_s2_r;
  logic act_d_r;
  logic begin_pend_r;
  logic cont_pend_r;
  logic [PTR_W-1:0] next_ptr_r;
  logic setup_req_r;
  logic setup_rel_r;
  logic [STAT_W-1:0] status_r;
  logic [CNT_W-1:0] drops_r;
  logic [HDS_W-1:0] hds_r;
  logic cmd_clear_r;
  logic dma_halt_r;
  logic rnr_r;
  logic frame_ev_r;
  logic status_upd_r;
  logic buf_in_ready;
  logic frame_end;
  logic accept;
  logic is_begin;
  logic is_cont;
  logic is_halt;
  logic go_ready;
  logic rel_now;

  // ==========================================================
  // line activity: two-flop synchroniser, edge taken from the second flop
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      act_s1_r <= 1'b0;
      act_s2_r <= 1'b0;
      act_d_r <= 1'b0;
    end
    else
    begin
      act_s1_r <= frame_active_i;
      act_s2_r <= act_s1_r; // actively receiving in every state
      act_d_r <= act_s2_r;
    end
  end

  assign frame_end = act_d_r && !act_s2_r;

  // ==========================================================
  // command acceptance: only once the command engine is done with its own
  assign accept = cmd_valid_i && cmd_engine_done_i && !cmd_clear_r;
  assign is_begin = accept && (cmd_i.code == CMD_BEGIN);
  assign is_cont = accept && (cmd_i.code == CMD_CONTINUE);
  assign is_halt = accept && (cmd_i.code == CMD_HALT);

  // ==========================================================
  // next state; halt wins over everything, including a descriptor retire
  always_comb
  begin
    state_nxt = state_r;
    go_ready = 1'b0;
    rel_now = 1'b0;
    if (is_halt)
    begin
      state_nxt = RX_IDLE;
    end
    else if (is_begin && !act_s2_r && state_r != RX_READY && !data_moved_i)
    begin
      state_nxt = RX_READY;
      go_ready = 1'b1;
      rel_now = 1'b1;
    end
    else if (is_cont && state_r == RX_SUSP && !act_s2_r)
    begin
      state_nxt = RX_READY;
      go_ready = 1'b1;
    end
    else if (frame_end && (begin_pend_r || (cont_pend_r && state_r == RX_SUSP)))
    begin
      state_nxt = RX_READY;
      go_ready = 1'b1;
    end
    else if (desc_done_i && state_r == RX_READY)
    begin
      if (desc_eol_i)
      begin
        state_nxt = RX_NORES;
      end
      else if (desc_susp_i)
      begin
        state_nxt = RX_SUSP;
      end
    end
  end

  // state register, idle out of reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= RX_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // pending flags remembered from acceptance until frame completion
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      begin_pend_r <= 1'b0;
      cont_pend_r <= 1'b0;
    end
    else
    begin
      if (is_halt || go_ready)
      begin
        begin_pend_r <= 1'b0;
        cont_pend_r <= 1'b0;
      end
      else if (is_begin && state_r != RX_READY)
      begin
        begin_pend_r <= act_s2_r; // set while a frame arrives, else cleared
      end
      else if (is_cont && state_r == RX_SUSP && act_s2_r)
      begin
        cont_pend_r <= 1'b1;
      end
    end
  end

  // next-descriptor pointer, taken from the area offset or the retired link
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      next_ptr_r <= '0;
    end
    else if (is_begin && state_r != RX_READY)
    begin
      next_ptr_r <= cmd_i.ptr;
    end
    else if (desc_done_i && state_r == RX_READY)
    begin
      next_ptr_r <= desc_link_i;
    end
  end

  // ==========================================================
  // set-up request held until the buffer takes it or a halt drops it; a retire while it waits replaces the pointer it carries
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      setup_req_r <= 1'b0;
      setup_rel_r <= 1'b0;
    end
    else if (is_halt)
    begin
      setup_req_r <= 1'b0;
      setup_rel_r <= 1'b0;
    end
    else if (go_ready || (desc_done_i && state_nxt == RX_READY && state_r == RX_READY))
    begin
      setup_req_r <= 1'b1;
      setup_rel_r <= rel_now;
    end
    else if (buf_in_ready)
    begin
      setup_req_r <= 1'b0;
      setup_rel_r <= 1'b0;
    end
  end

  rxctl_fifo2 #(
    .WIDTH(SETUP_W)
  ) u_setup_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(setup_req_r),
    .in_ready_o(buf_in_ready),
    .in_data_i({setup_rel_r, next_ptr_r}),
    .out_valid_o(setup_valid_o),
    .out_ready_i(setup_ready_i),
    .out_data_o(setup_o)
  );

  // ==========================================================
  // one-cycle events; the command byte is cleared the cycle after acceptance
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_clear_r <= 1'b0;
      dma_halt_r <= 1'b0;
      rnr_r <= 1'b0;
      frame_ev_r <= 1'b0;
    end
    else
    begin
      cmd_clear_r <= accept;
      dma_halt_r <= is_halt;
      rnr_r <= is_halt && state_r == RX_READY;
      frame_ev_r <= desc_done_i || hdr_done_i;
    end
  end

  // header size loaded by its own command
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hds_r <= '0;
    end
    else if (accept && cmd_i.code == CMD_LOAD_HEADER_SIZE_CMD)
    begin
      hds_r <= cmd_i.ptr[HDS_W-1:0];
    end
  end

  // discarded frames counted only while out of descriptors
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      drops_r <= '0;
    end
    else if (frame_end && state_r == RX_NORES)
    begin
      drops_r <= drops_r + CNT_W'(1);
    end
  end

  // ==========================================================
  // status word refreshed one cycle after each reporting event
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_r <= '0;
      status_upd_r <= 1'b0;
    end
    else if (cmd_clear_r || state_nxt != state_r || frame_ev_r || flagged_cmd_done_i)
    begin
      status_r <= '0;
      status_r[STAT_RU_LSB +: 4] <= rxctl_code(state_nxt);
      status_upd_r <= 1'b1;
    end
    else
    begin
      status_upd_r <= 1'b0;
    end
  end

  assign discard_o = (state_r != RX_READY);
  assign cmd_clear_o = cmd_clear_r;
  assign dma_halt_o = dma_halt_r;
  assign rnr_event_o = rnr_r;
  assign frame_event_o = frame_ev_r;
  assign status_word_o = status_r;
  assign status_update_o = status_upd_r;
  assign nores_drops_o = drops_r;
  assign hdr_size_o = hds_r;

  // ==========================================================
  // checks
  a_halt_to_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    is_halt |=> (state_r == RX_IDLE) && dma_halt_o)
    else $error("halt did not reach idle with DMA halt");
  a_halt_rnr: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_halt && state_r == RX_READY) |=> rnr_event_o)
    else $error("halt while ready gave no receiver-not-ready event");
  a_cont_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_cont && state_r != RX_SUSP) |=> $stable(state_r) && !cont_pend_r)
    else $error("continue outside suspended changed the engine");
  a_eol_nores: assert property (@(posedge clk_i) disable iff (rst_i)
    (desc_done_i && desc_eol_i && state_r == RX_READY && !accept) |=> state_r == RX_NORES)
    else $error("end-of-list descriptor did not reach no-resources");
  a_status_code: assert property (@(posedge clk_i) disable iff (rst_i)
    status_update_o |-> status_word_o[STAT_RU_LSB +: 4] == rxctl_code(state_r))
    else $error("status word state field disagrees with engine");
  a_clear_once: assert property (@(posedge clk_i) disable iff (rst_i)
    accept |=> cmd_clear_o ##1 !cmd_clear_o)
    else $error("command byte clear not a single pulse after acceptance");
  a_accept_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_clear_o |-> $past(cmd_engine_done_i))
    else $error("command taken before command engine finished");
  a_pend_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_end && begin_pend_r && !accept) |=> state_r == RX_READY ##1 !begin_pend_r)
    else $error("pending begin not honoured at frame end");
  a_begin_idle_line: assert property (@(posedge clk_i) disable iff (rst_i)
    (is_begin && !act_s2_r && state_r != RX_READY && !data_moved_i)
      |=> state_r == RX_READY && setup_req_r && next_ptr_r == $past(cmd_i.ptr))
    else $error("begin on quiet line did not enter ready with set-up");
  a_status_on_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_event_o |=> status_update_o)
    else $error("frame completion did not refresh status");

endmodule : rxctl_engine

// file: verilog/rxctl_fifo2.sv
// two-entry valid/ready buffer for descriptor set-up requests
`timescale 1ns/1ps
module rxctl_fifo2
  import rxctl_pkg::*;
#(
  parameter int WIDTH = SETUP_W
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  // honest full/empty straight from the occupancy count
  assign in_ready_o = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage, no reset needed on data
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
      begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop)
      begin
        count_r <= count_r + 2'h1;
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 2'h1;
      end
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_r == 2'h2 && !pop) |=> (count_r == 2'h2))
    else $error("buffer occupancy changed while full and not drained");

endmodule : rxctl_fifo2

// file: verilog/rxctl_pkg.sv
// constants, types and helpers shared by the receive-engine control block
package rxctl_pkg;

  // ==========================================================
  // receive_engine state codes as seen in the status word
  localparam logic [3:0] RX_CODE_IDLE = 4'h0;
  localparam logic [3:0] RX_CODE_NORES = 4'h2;
  localparam logic [3:0] RX_CODE_SUSP = 4'h1;
  localparam logic [3:0] RX_CODE_READY = 4'h4;
  localparam int STAT_RU_LSB = 2;
  localparam int STAT_W = 16;
  localparam int PTR_W = 16;
  localparam int HDS_W = 16;
  localparam int CNT_W = 16;

  // ==========================================================
  // receive control field commands
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_BEGIN = 3'h1;
  localparam logic [2:0] CMD_CONTINUE = 3'h2;
  localparam logic [2:0] CMD_HALT = 3'h4;
  localparam logic [2:0] CMD_LOAD_HEADER_SIZE_CMD = 3'h5;

  typedef enum logic [1:0] {RX_IDLE, RX_NORES, RX_SUSP, RX_READY} rxctl_state_type;

  // command handed over by the command engine
  typedef struct packed {
    logic [2:0] code;
    logic [PTR_W-1:0] ptr;
  } rxctl_cmd_type;

  // descriptor set-up request towards the receive DMA
  typedef struct packed {
    logic release_prefetch;
    logic [PTR_W-1:0] ptr;
  } rxctl_setup_type;

  localparam int SETUP_W = PTR_W + 1;

  function automatic logic [3:0] rxctl_code(input rxctl_state_type s);
    unique case (s)
      RX_IDLE: rxctl_code = RX_CODE_IDLE;
      RX_NORES: rxctl_code = RX_CODE_NORES;
      RX_SUSP: rxctl_code = RX_CODE_SUSP;
      RX_READY: rxctl_code = RX_CODE_READY;
    endcase
  endfunction : rxctl_code

endpackage : rxctl_pkg
